/* rtl/bpg_defines.vh */
`ifndef BPG_DEFINES_VH
`define BPG_DEFINES_VH

// ==========================================================
// Register indices (byte address = index * 4)
`define BPG_IDX_HIGH_DATA     4'h0
`define BPG_IDX_LOW_DATA      4'h1
`define BPG_IDX_HIGH_DIR      4'h2
`define BPG_IDX_LOW_DIR       4'h3
`define BPG_IDX_RSVD_FIRST    4'h4
`define BPG_IDX_RSVD_LAST     4'h7
`define BPG_IDX_CTRL_DATA     4'h8
`define BPG_IDX_CTRL_DIR      4'h9
`define BPG_IDX_PIN_ASSIGN    4'ha
`define BPG_IDX_PULL_CTRL     4'hc

// ==========================================================
// Field positions
`define BPG_PA_NOACC_BIT      7
`define BPG_PA_PIPE_BIT       5
`define BPG_PA_NOECLK_BIT     4
`define BPG_PA_LSTR_BIT       3
`define BPG_PA_RDWR_BIT       2
`define BPG_PULL_CTRL_BIT     4
`define BPG_CTRL_BIDIR_MASK   8'hfc
`define BPG_PA_IMPL_MASK      8'hbc

// ==========================================================
// Reset values
`define BPG_RST_DATA          8'h00
`define BPG_RST_DIR           8'h00
`define BPG_RST_PIN_ASSIGN    8'h90
`define BPG_RST_PULL          1'b0

// ==========================================================
// Timing: APB answer after one wait state
`define BPG_APB_WAIT          1

`endif

/* rtl/bpg_bus_port_gpio.v */
// Overview of operation
// - In expanded mode high port bits 7..0 carry A15..A8 and matching data lines.
// - In expanded mode low port bits 7..0 carry A7..A0 and D7..D0.
// - Without external addressing both ports act as GPIO under their direction registers.
// - Direction 1 drives the pin as output; direction 0 leaves it high-impedance input.
// - Data read returns pin level where direction is 0, latch where direction is 1.
// - High/low data and direction registers vanish in expanded/peripheral modes; access echoes out.
// - High and low direction registers reset to zero.
// - Reserved locations and unused bits read zero; writes do nothing.
// - Reserved locations vanish from the map in special peripheral mode.
// - Control pins 7..2 are bidirectional GPIO; pins 1..0 are inputs only.
// - Pin assignment picks function; direction matters only for GPIO-configured control pins.
// - Alternate functions: pipe status, bus clock, strobe/tag, read/write, two interrupts.
// - One bit enables control-port pulls on inputs of pins 7 and 4..0 (never 6..5); interrupt pins pull up only.
// - Control data register vanishes in peripheral mode, or expanded with emulate bit set.
// - Control bits 1..0 never become outputs and always stay readable.
// - Control direction vanishes in expanded/peripheral modes, or expanded with emulate bit.
// - An alternate control function overrides that pin's direction bit.
`timescale 1ns/10ps
`default_nettype none
`include "bpg_defines.vh"

module bpg_bus_port_gpio #(
    parameter ADDR_W = 12
) (
    // Clock and reset
    input  wire              clk,
    input  wire              arst_n,
    // APB slave
    input  wire              psel,
    input  wire              penable,
    input  wire              pwrite,
    input  wire [ADDR_W-1:0] paddr,
    input  wire [31:0]       pwdata,
    output reg               pready,
    output reg  [31:0]       prdata,
    output reg               pslverr,
    // Operating mode
    input  wire              modeExpanded,
    input  wire              modeSpecialPeriph,
    input  wire              emulatePortEBit,
    // Echo of accesses to locations that are off the on-chip map
    output reg               extEchoValid,
    output reg               extEchoWrite,
    output reg  [3:0]        extEchoIndex,
    output reg  [7:0]        extEchoData,
    // External bus drive for the high and low ports
    input  wire [7:0]        busHighOut,
    input  wire [7:0]        busHighOe,
    input  wire [7:0]        busLowOut,
    input  wire [7:0]        busLowOe,
    // High port pins
    input  wire [7:0]        highPinIn,
    output reg  [7:0]        highPinOut,
    output reg  [7:0]        highPinOe,
    // Low port pins
    input  wire [7:0]        lowPinIn,
    output reg  [7:0]        lowPinOut,
    output reg  [7:0]        lowPinOe,
    // Control port alternate outputs, bits 7..2
    input  wire [7:0]        ctrlAltOut,
    input  wire [7:0]        ctrlAltOe,
    // Control port pins
    input  wire [7:0]        ctrlPinIn,
    output reg  [7:0]        ctrlPinOut,
    output reg  [7:0]        ctrlPinOe,
    output reg  [7:0]        ctrlPullEn,
    output reg  [7:0]        ctrlAltSel,
    // Interrupt request levels, active low
    output reg               irqReqN,
    output reg               nmiReqN
);

    // ==========================================================
    // Reset synchroniser
    reg rstMeta_q;
    reg rstSync_q;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end

    wire rstN = rstSync_q;

    // ==========================================================
    // Helpers
    function [7:0] portRead;
        input [7:0] dir;
        input [7:0] latch;
        input [7:0] pin;
        begin
            portRead = (dir & latch) | (~dir & pin);
        end
    endfunction

    // ==========================================================
    // Registers
    reg  [7:0] highData_q;
    reg  [7:0] lowData_q;
    reg  [7:0] highDir_q;
    reg  [7:0] lowDir_q;
    reg  [7:0] ctrlData_q;
    reg  [7:0] ctrlDir_q;
    reg  [7:0] pinAssign_q;
    reg        pullEn_q;

    // ==========================================================
    // Map visibility
    wire abInMap     = ~modeExpanded & ~modeSpecialPeriph;
    wire rsvdInMap   = ~modeSpecialPeriph;
    wire eDataInMap  = ~modeSpecialPeriph & ~(modeExpanded & emulatePortEBit);
    wire eDirInMap   = ~modeExpanded & ~modeSpecialPeriph;
    wire paInMap     = ~modeExpanded & ~modeSpecialPeriph;

    // ==========================================================
    // Control port function selection
    reg [7:0] altSel;

    always @* begin
        altSel = 8'h00;
        // Pin assignment has no effect in single-chip or peripheral modes, except the clock pin
        if (modeExpanded & ~modeSpecialPeriph) begin
            altSel[7] = ~pinAssign_q[`BPG_PA_NOACC_BIT];
            altSel[6] = pinAssign_q[`BPG_PA_PIPE_BIT];
            altSel[5] = pinAssign_q[`BPG_PA_PIPE_BIT];
            altSel[3] = pinAssign_q[`BPG_PA_LSTR_BIT];
            altSel[2] = pinAssign_q[`BPG_PA_RDWR_BIT];
        end
        altSel[4] = ~pinAssign_q[`BPG_PA_NOECLK_BIT];
    end

    // Effective directions; bits 1..0 are input only
    wire [7:0] ctrlDirEff = ctrlDir_q & `BPG_CTRL_BIDIR_MASK & ~altSel;

    // ==========================================================
    // APB decode
    wire       addrOk = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:6] == {(ADDR_W-6){1'b0}});
    wire [3:0] idx    = paddr[5:2];
    wire       isRsvd = (idx >= `BPG_IDX_RSVD_FIRST) && (idx <= `BPG_IDX_RSVD_LAST);

    reg        hit;
    reg        echo;
    reg [7:0]  rdByte;

    always @* begin
        hit    = 1'b0;
        echo   = 1'b0;
        rdByte = 8'h00;
        if (addrOk) begin
            case (idx)
                `BPG_IDX_HIGH_DATA: begin
                    hit    = abInMap;
                    rdByte = portRead(highDir_q, highData_q, highPinIn);
                end
                `BPG_IDX_LOW_DATA: begin
                    hit    = abInMap;
                    rdByte = portRead(lowDir_q, lowData_q, lowPinIn);
                end
                `BPG_IDX_HIGH_DIR: begin
                    hit    = abInMap;
                    rdByte = highDir_q;
                end
                `BPG_IDX_LOW_DIR: begin
                    hit    = abInMap;
                    rdByte = lowDir_q;
                end
                `BPG_IDX_CTRL_DATA: begin
                    hit    = eDataInMap;
                    rdByte = portRead(ctrlDirEff, ctrlData_q, ctrlPinIn);
                end
                `BPG_IDX_CTRL_DIR: begin
                    hit    = eDirInMap;
                    rdByte = ctrlDir_q & `BPG_CTRL_BIDIR_MASK;
                end
                `BPG_IDX_PIN_ASSIGN: begin
                    hit    = paInMap;
                    rdByte = pinAssign_q & `BPG_PA_IMPL_MASK;
                end
                `BPG_IDX_PULL_CTRL: begin
                    hit    = 1'b1;
                    rdByte = {3'b000, pullEn_q, 4'h0};
                end
                default: begin
                    hit    = isRsvd & rsvdInMap;
                    rdByte = 8'h00;
                end
            endcase
            if (!hit) begin
                case (idx)
                    `BPG_IDX_HIGH_DATA, `BPG_IDX_LOW_DATA,
                    `BPG_IDX_HIGH_DIR, `BPG_IDX_LOW_DIR,
                    `BPG_IDX_CTRL_DATA, `BPG_IDX_CTRL_DIR,
                    `BPG_IDX_PIN_ASSIGN: begin
                        echo = 1'b1;
                    end
                    default: begin
                        echo = isRsvd;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // APB handshake: one wait state, then the access completes
    wire accessPhase = psel & penable;
    wire completing  = accessPhase & pready;
    wire doWrite     = completing & pwrite & hit;

    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pready       <= 1'b0;
            prdata       <= 32'h0000_0000;
            pslverr      <= 1'b0;
            extEchoValid <= 1'b0;
            extEchoWrite <= 1'b0;
            extEchoIndex <= 4'h0;
            extEchoData  <= 8'h00;
        end else begin
            pready       <= accessPhase & ~pready;
            extEchoValid <= 1'b0;
            if (accessPhase & ~pready) begin
                prdata  <= pwrite ? 32'h0000_0000 : {24'h00_0000, rdByte};
                pslverr <= ~hit & ~echo;
            end
            if (completing & echo) begin
                extEchoValid <= 1'b1;
                extEchoWrite <= pwrite;
                extEchoIndex <= idx;
                extEchoData  <= pwdata[7:0];
            end
        end
    end

    // ==========================================================
    // Register writes; reserved locations and unused bits ignore writes
    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            highData_q  <= `BPG_RST_DATA;
            lowData_q   <= `BPG_RST_DATA;
            highDir_q   <= `BPG_RST_DIR;
            lowDir_q    <= `BPG_RST_DIR;
            ctrlData_q  <= `BPG_RST_DATA;
            ctrlDir_q   <= `BPG_RST_DIR;
            pinAssign_q <= `BPG_RST_PIN_ASSIGN;
            pullEn_q    <= `BPG_RST_PULL;
        end else if (doWrite) begin
            case (idx)
                `BPG_IDX_HIGH_DATA:  highData_q  <= pwdata[7:0];
                `BPG_IDX_LOW_DATA:   lowData_q   <= pwdata[7:0];
                `BPG_IDX_HIGH_DIR:   highDir_q   <= pwdata[7:0];
                `BPG_IDX_LOW_DIR:    lowDir_q    <= pwdata[7:0];
                `BPG_IDX_CTRL_DATA:  ctrlData_q  <= pwdata[7:0];
                `BPG_IDX_CTRL_DIR:   ctrlDir_q   <= pwdata[7:0] & `BPG_CTRL_BIDIR_MASK;
                `BPG_IDX_PIN_ASSIGN: pinAssign_q <= pwdata[7:0] & `BPG_PA_IMPL_MASK;
                `BPG_IDX_PULL_CTRL:  pullEn_q    <= pwdata[`BPG_PULL_CTRL_BIT];
                default:             pullEn_q    <= pullEn_q;
            endcase
        end
    end

    // ==========================================================
    // Pin drive, registered so each output comes from a flop
    wire busOwnsAB = modeExpanded | modeSpecialPeriph;

    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            highPinOut <= 8'h00;
            highPinOe  <= 8'h00;
            lowPinOut  <= 8'h00;
            lowPinOe   <= 8'h00;
        end else if (busOwnsAB) begin
            highPinOut <= busHighOut;
            highPinOe  <= busHighOe;
            lowPinOut  <= busLowOut;
            lowPinOe   <= busLowOe;
        end else begin
            highPinOut <= highData_q;
            highPinOe  <= highDir_q;
            lowPinOut  <= lowData_q;
            lowPinOe   <= lowDir_q;
        end
    end

    // Control port: alternate function wins over the direction bit
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : gCtrlPin
            always @(posedge clk or negedge rstN) begin
                if (!rstN) begin
                    ctrlPinOut[g] <= 1'b0;
                    ctrlPinOe[g]  <= 1'b0;
                    ctrlPullEn[g] <= 1'b0;
                    ctrlAltSel[g] <= 1'b0;
                end else begin
                    ctrlAltSel[g] <= altSel[g];
                    if (g < 2) begin
                        // Interrupt pins are never driven; pull is upward only
                        ctrlPinOut[g] <= 1'b0;
                        ctrlPinOe[g]  <= 1'b0;
                        ctrlPullEn[g] <= pullEn_q;
                    end else if (altSel[g]) begin
                        ctrlPinOut[g] <= ctrlAltOut[g];
                        ctrlPinOe[g]  <= ctrlAltOe[g];
                        ctrlPullEn[g] <= pullEn_q & ~ctrlAltOe[g] & ((g == 7) || (g == 4) ||
                                         (g == 3) || (g == 2));
                    end else begin
                        ctrlPinOut[g] <= ctrlData_q[g];
                        ctrlPinOe[g]  <= ctrlDir_q[g];
                        ctrlPullEn[g] <= pullEn_q & ~ctrlDir_q[g] & ((g == 7) || (g == 4) ||
                                         (g == 3) || (g == 2));
                    end
                end
            end
        end
    endgenerate

    // Interrupt levels pass through a flop; pin reads stay independent of them
    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            irqReqN <= 1'b1;
            nmiReqN <= 1'b1;
        end else begin
            irqReqN <= ctrlPinIn[1];
            nmiReqN <= ctrlPinIn[0];
        end
    end

endmodule // bpg_bus_port_gpio

`default_nettype wire

/* verif/bpg_pin_world.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Pins and outside devices around the ports
module bpg_pin_world (
    // Drive from the port block
    input  wire logic [7:0] highOut, highOe, lowOut, lowOe, ctrlOut, ctrlOe,
    // Levels that outside devices put on undriven pins
    input  wire logic [7:0] extHigh, extLow, extCtrl,
    // Resolved pin levels
    output wire logic [7:0] highLvl, lowLvl, ctrlLvl
);
    // An outside device always drives an undriven pin, so no pin is left to the simulator's choice
    assign highLvl = (highOut & highOe) | (extHigh & ~highOe);
    assign lowLvl  = (lowOut & lowOe) | (extLow & ~lowOe);
    assign ctrlLvl = (ctrlOut & ctrlOe) | (extCtrl & ~ctrlOe);
endmodule // bpg_pin_world
`default_nettype wire

/* verif/bpg_bus_port_gpio_sva.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Port-level checks
module bpg_gpio_chk #(parameter ADDR_W = 12) (
    // Bus side
    input wire logic              clk, arst_n, psel, penable, pwrite, pready, pslverr,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       prdata, pwdata,
    // Mode, echo and pins
    input wire logic              modeExpanded, modeSpecialPeriph, emulatePortEBit, extEchoValid, irqReqN,
    input wire logic [3:0]        extEchoIndex,
    input wire logic [7:0]        busHighOut, busHighOe, busLowOe, highPinIn, highPinOut, highPinOe,
    input wire logic [7:0]        lowPinOe, ctrlAltOe, ctrlPinIn, ctrlPinOe, ctrlAltSel
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic [1:0] upCnt_q;
    // Internal reset lags the pin by two edges, so checks wait for the third
    wire       up = upCnt_q == 2'd3;
    wire [3:0] idx = paddr[5:2];
    wire       hs = psel && penable && pready;
    wire       sc = !modeExpanded && !modeSpecialPeriph;
    wire [7:0] wByte = pwdata[7:0];
    wire       irqPin = ctrlPinIn[1];
    wire       alt4 = ctrlAltSel[4];
    wire       altOe4 = ctrlAltOe[4];
    wire       off = ((idx < 4'h4 || idx == 4'h9 || idx == 4'ha) && !sc) || (idx[3:2] == 2'b01 && modeSpecialPeriph)
                     || (idx == 4'h8 && (modeSpecialPeriph || (modeExpanded && emulatePortEBit)));
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n) upCnt_q <= 2'd0;
        else if (!up) upCnt_q <= upCnt_q + 2'd1;

    a_dir_drives_pin: assert property (up && hs && pwrite && sc && idx == 4'h2 |-> ##2 highPinOe == $past(wByte, 2))
        else $error("high enable differs from direction");
    a_read_source: assert property (up && hs && !pwrite && sc && idx == 4'h0
        |-> prdata[7:0] == (($past(highPinIn) & ~$past(highPinOe)) | ($past(highPinOut) & $past(highPinOe))))
        else $error("high data read source wrong");
    a_echo_offmap: assert property (up && hs && off |=> extEchoValid && extEchoIndex == $past(idx))
        else $error("off-map access not echoed");
    a_echo_inmap: assert property (up && hs && !off && idx <= 4'ha |=> !extEchoValid)
        else $error("in-map access echoed");
    a_rsvd_zero: assert property (hs && !pwrite && idx[3:2] == 2'b01 |-> prdata == 32'h0 && !pslverr)
        else $error("reserved read not zero");
    a_bus_owns: assert property (up && $past(modeExpanded) && modeExpanded
        |-> highPinOut == $past(busHighOut) && highPinOe == $past(busHighOe) && lowPinOe == $past(busLowOe))
        else $error("bus does not own pins");
    a_ctrl_low_in: assert property (ctrlPinOe[1:0] == 2'b00)
        else $error("control pin 1 or 0 driven");
    a_irq_copy: assert property (up |-> irqReqN == $past(irqPin))
        else $error("interrupt level not following pin");
    a_dir_reset: assert property ($rose(up) && sc |-> highPinOe == 8'h00 && lowPinOe == 8'h00)
        else $error("pins driven after reset");
    a_alt_override: assert property (up && $past(alt4) && alt4 |-> ctrlPinOe[4] == $past(altOe4))
        else $error("alternate function not overriding direction");

    c_echo: cover property (hs && off);
    c_gpio_read: cover property (hs && !pwrite && sc && idx == 4'h0);
    c_alt: cover property (up && alt4);
endmodule // bpg_gpio_chk

bind bpg_bus_port_gpio bpg_gpio_chk #(.ADDR_W(ADDR_W)) u_chk (
    .clk, .arst_n, .psel, .penable, .pwrite, .pready, .pslverr, .paddr, .prdata, .pwdata, .modeExpanded,
    .modeSpecialPeriph, .emulatePortEBit, .extEchoValid, .irqReqN, .extEchoIndex, .busHighOut, .busHighOe,
    .busLowOe, .highPinIn, .highPinOut, .highPinOe, .lowPinOe, .ctrlAltOe, .ctrlPinIn, .ctrlPinOe, .ctrlAltSel);
`default_nettype wire

/* verif/tb_bus_port_gpio_registers.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Self-checking bench for the port registers
module tb_bus_port_gpio_registers;
    logic        clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, lastErr;
    logic        modeExpanded = 1'b0, modeSpecialPeriph = 1'b0, emulatePortEBit = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [7:0]  busHighOut = 8'h00, busHighOe = 8'h00, busLowOut = 8'h00, busLowOe = 8'h00;
    logic [7:0]  ctrlAltOut = 8'h00, ctrlAltOe = 8'h00, extHigh = 8'h5a, extLow = 8'hc3, extCtrl = 8'h02;
    wire         pready, pslverr, extEchoValid, extEchoWrite, irqReqN, nmiReqN;
    wire  [31:0] prdata;
    wire  [3:0]  extEchoIndex;
    wire  [7:0]  extEchoData, highPinIn, highPinOut, highPinOe, lowPinIn, lowPinOut, lowPinOe;
    wire  [7:0]  ctrlPinIn, ctrlPinOut, ctrlPinOe, ctrlPullEn, ctrlAltSel;
    int          n_fail = 0, checks = 0;

    bpg_bus_port_gpio DUT (
        .clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .modeExpanded,
        .modeSpecialPeriph, .emulatePortEBit, .extEchoValid, .extEchoWrite, .extEchoIndex, .extEchoData,
        .busHighOut, .busHighOe, .busLowOut, .busLowOe, .highPinIn, .highPinOut, .highPinOe, .lowPinIn,
        .lowPinOut, .lowPinOe, .ctrlAltOut, .ctrlAltOe, .ctrlPinIn, .ctrlPinOut, .ctrlPinOe, .ctrlPullEn,
        .ctrlAltSel, .irqReqN, .nmiReqN);
    bpg_pin_world u_world (
        .highOut(highPinOut), .highOe(highPinOe), .lowOut(lowPinOut), .lowOe(lowPinOe), .ctrlOut(ctrlPinOut),
        .ctrlOe(ctrlPinOe), .extHigh, .extLow, .extCtrl, .highLvl(highPinIn), .lowLvl(lowPinIn),
        .ctrlLvl(ctrlPinIn));

    always #5 clk = ~clk;

    task automatic end_sim;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    // One transfer plus an idle cycle, so a direction change settles before any read
    task automatic apb(input logic wr, input logic [3:0] ix, input logic [7:0] wd, output logic [31:0] rd);
        int n;
        n = 0;
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {6'h00, ix, 2'b00};
        pwdata  <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_fail++;
            end_sim;
        end
        rd = prdata;
        lastErr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rdchk(input string what, input logic [3:0] ix, input logic [31:0] exp);
        logic [31:0] r;
        apb(1'b0, ix, 8'h00, r);
        cmp(what, exp, r);
    endtask

    task automatic echo(input logic [3:0] ix, input logic [31:0] exp);
        cmp("echo valid", exp, {31'h0, extEchoValid});
        if (exp == 32'h1) cmp("echo index", {28'h0, ix}, {28'h0, extEchoIndex});
    endtask

    task automatic s_reset;
        rdchk("high dir", 4'h2, 32'h0);
        rdchk("low dir", 4'h3, 32'h0);
        rdchk("high data", 4'h0, 32'h5a);
        rdchk("pin assign", 4'ha, 32'h90);
    endtask

    task automatic s_gpio;
        logic [31:0] r;
        for (int p = 0; p < 2; p++) begin
            apb(1'b1, p[3:0], 8'ha5, r);
            rdchk("data as input", p[3:0], {24'h0, p ? extLow : extHigh});
            apb(1'b1, 4'h2 + p[3:0], 8'hf0, r);
            rdchk("mixed read", p[3:0], {24'h0, 8'ha0 | ((p ? extLow : extHigh) & 8'h0f)});
            cmp("pin enable", 32'hf0, {24'h0, p ? lowPinOe : highPinOe});
            cmp("pin value", 32'ha0, {24'h0, (p ? lowPinOut : highPinOut) & 8'hf0});
        end
    endtask

    task automatic s_rsvd;
        logic [31:0] r;
        for (int i = 4; i < 8; i++) begin
            apb(1'b1, i[3:0], 8'hff, r);
            rdchk("reserved", i[3:0], 32'h0);
        end
        apb(1'b0, 4'hb, 8'h00, r);
        cmp("slave error", 32'h1, {31'h0, lastErr});
        modeSpecialPeriph <= 1'b1;
        @(posedge clk);
        apb(1'b0, 4'h5, 8'h00, r);
        echo(4'h5, 32'h1);
        apb(1'b1, 4'h8, 8'h11, r);
        echo(4'h8, 32'h1);
        modeSpecialPeriph <= 1'b0;
        @(posedge clk);
    endtask

    task automatic s_expanded;
        logic [31:0] r;
        modeExpanded <= 1'b1;
        busHighOut   <= 8'h3c;
        busHighOe    <= 8'hff;
        busLowOe     <= 8'h0f;
        @(posedge clk);
        apb(1'b1, 4'h0, 8'h77, r);
        echo(4'h0, 32'h1);
        cmp("echo data", 32'h77, {24'h0, extEchoData});
        cmp("echo write", 32'h1, {31'h0, extEchoWrite});
        cmp("bus high", 32'h3c, {24'h0, highPinOut});
        cmp("bus low enable", 32'h0f, {24'h0, lowPinOe});
        apb(1'b0, 4'h9, 8'h00, r);
        echo(4'h9, 32'h1);
        apb(1'b0, 4'h8, 8'h00, r);
        echo(4'h8, 32'h0);
        emulatePortEBit <= 1'b1;
        @(posedge clk);
        apb(1'b0, 4'h8, 8'h00, r);
        echo(4'h8, 32'h1);
        modeExpanded    <= 1'b0;
        emulatePortEBit <= 1'b0;
        busHighOe       <= 8'h00;
        busLowOe        <= 8'h00;
        @(posedge clk);
        rdchk("high data kept", 4'h0, 32'haa);
    endtask

    task automatic s_ctrl;
        logic [31:0] r;
        apb(1'b1, 4'h8, 8'hff, r);
        apb(1'b1, 4'h9, 8'hff, r);
        rdchk("ctrl dir", 4'h9, 32'hfc);
        cmp("ctrl enable", 32'hfc, {24'h0, ctrlPinOe});
        rdchk("ctrl data", 4'h8, 32'hfe);
        cmp("irq levels", 32'h2, {30'h0, irqReqN, nmiReqN});
        apb(1'b1, 4'ha, 8'h80, r);
        repeat (2) @(posedge clk);
        cmp("alt select", 32'h1, {31'h0, ctrlAltSel[4]});
        cmp("alt enable", 32'h0, {31'h0, ctrlPinOe[4]});
        cmp("ctrl out", 32'hec, {24'h0, ctrlPinOut});
        apb(1'b1, 4'hc, 8'h10, r);
        @(posedge clk);
        // Pins 1..0 always pulled; pin 4 is an undriven alternate input; 7,3,2 are outputs
        cmp("ctrl pull", 32'h13, {24'h0, ctrlPullEn});
    endtask

    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        s_reset;
        s_gpio;
        s_rsvd;
        s_expanded;
        s_ctrl;
        end_sim;
    end
endmodule // tb_bus_port_gpio_registers
`default_nettype wire
